// ---- rtl/gpp_level_sync.sv ----
// Pin level synchroniser: a latch open while the clock is high followed by
// a rising-edge register.
// Assumes d comes from outside the clock domain.
`timescale 1ns/10ps
module gpp_level_sync #(
  parameter int unsigned WIDTH = 8
) (
  input  wire logic             sys_clk_i,
  input  wire logic             nrst_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] sync_latch;
  logic [WIDTH-1:0] next_q;

  // Transparent in the high phase, holds the value seen at the fall
  // Non-blocking so the rising-edge register sees the value held at the fall
  always_latch begin
    if (!nrst_i) begin
      sync_latch <= '0;
    end else if (sys_clk_i) begin
      sync_latch <= d_i;
    end
  end

  // Held value loaded at the next rising edge
  always_comb begin
    next_q = sync_latch;
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      q_o <= '0;
    end else begin
      q_o <= next_q;
    end
  end
endmodule

// ---- rtl/gpp_pin_if.sv ----
// Per-pin bundle between the port register logic and one pin slice.
// Assumes the top module drives every control field and the slice answers.
`timescale 1ns/10ps
interface gpp_pin_if;
  logic direction_bit;
  logic output_latch_bit;
  logic global_pullup_disable;
  logic sleep;
  logic ext_int_enable;
  logic reset_active;
  logic pullup_override_enable;
  logic pullup_override_value;
  logic direction_override_enable;
  logic direction_override_value;
  logic drive_value_override_enable;
  logic drive_value_override_value;
  logic latch_invert_override_enable;
  logic input_enable_override_enable;
  logic input_enable_override_value;
  logic pad_in;
  logic pad_out;
  logic pad_oe;
  logic pullup_en;
  logic alt_function_digital_in;

  // Port side drives controls, reads results
  modport port (
    output direction_bit, output_latch_bit, global_pullup_disable, sleep,
           ext_int_enable, reset_active, pullup_override_enable,
           pullup_override_value, direction_override_enable,
           direction_override_value, drive_value_override_enable,
           drive_value_override_value, latch_invert_override_enable,
           input_enable_override_enable, input_enable_override_value, pad_in,
    input  pad_out, pad_oe, pullup_en, alt_function_digital_in
  );

  // Pin slice side
  modport pin (
    input  direction_bit, output_latch_bit, global_pullup_disable, sleep,
           ext_int_enable, reset_active, pullup_override_enable,
           pullup_override_value, direction_override_enable,
           direction_override_value, drive_value_override_enable,
           drive_value_override_value, latch_invert_override_enable,
           input_enable_override_enable, input_enable_override_value, pad_in,
    output pad_out, pad_oe, pullup_en, alt_function_digital_in
  );
endinterface

// ---- rtl/gpp_pin_slice.sv ----
// Combinational pad control of one pin: pull-up, driver enable, drive level
// and input enable with the sleep clamp.
// Assumes pad_in already carries the pad level and controls are registered.
`timescale 1ns/10ps
module gpp_pin_slice (
  gpp_pin_if.pin p
);
  logic eff_latch;
  logic pu_normal;
  logic in_enable;

  // Pad control terms
  always_comb begin
    eff_latch = p.output_latch_bit ^ p.latch_invert_override_enable;
    pu_normal = ({p.direction_bit, eff_latch, p.global_pullup_disable}
                 == 3'h2);
    // Input follows its override when enabled, else on unless sleeping without an enabled external interrupt
    in_enable = p.input_enable_override_enable ?
                p.input_enable_override_value :
                !(p.sleep && !p.ext_int_enable);
  end

  // Pull-up and driver are dropped at once while reset is active
  assign p.pullup_en = !p.reset_active &&
                       (p.pullup_override_enable ?
                        p.pullup_override_value : pu_normal);
  assign p.pad_oe = !p.reset_active &&
                    (p.direction_override_enable ?
                     p.direction_override_value :
                     p.direction_bit);
  assign p.pad_out = p.drive_value_override_enable ?
                     p.drive_value_override_value : eff_latch;
  // Clamped value goes to alternate functions before any synchroniser
  assign p.alt_function_digital_in = in_enable && p.pad_in;
endmodule

// ---- rtl/gpp_pkg.sv ----
// Constants shared by the general-purpose port: register map, reset values,
// bus response codes and the pin count of one port.
// Assumes an AXI4-Lite register bus with 32-bit data, one clock domain.
//
// Operation
// - Pin level readable whatever direction; passes a latch then a register.
// - Latch open while clock high; held value registered at next rise.
// - External pin change reaches level bit after half to one and half periods.
// - Software-driven pin value reappears after exactly one clock period.
// - Sleep signal clamps every digital pin input to ground in deep sleep.
// - Clamp skipped for pins with external interrupt enabled.
// - Released clamp on wake lets disabled edge interrupts see a change.
// - Pull-up forced off while the device is held in reset.
// - Pull-up follows override value, else on when dir,latch,pud is 010.
// - Direction override enable selects override value over direction bit.
// - Driven level from value override when enabled, else latch bit.
// - Toggle override enable inverts the output latch bit.
// - Input enable override decides input enable, else sleep state decides.
// - Alternate functions get the unsynchronised Schmitt-trigger output.
// - Analog alternate signal connects straight to the pad.
// - Strobes shared per port; clock, sleep, pull-up disable shared by all.
// - Override signals come from the owning peripheral, not port logic.
// - Direction bit one makes an output, zero an input.
// - Latch bit enables pull-up on inputs, sets level on outputs.
// - Writing one to a level bit toggles its latch bit; zero ignored.
// - All pins go high-impedance as soon as reset is active.
package gpp_pkg;

  localparam int unsigned PIN_COUNT = 8;

  // Register byte offsets
  localparam logic [31:0] OFS_DIRECTION = 32'h0000_0000;
  localparam logic [31:0] OFS_LATCH     = 32'h0000_0004;
  localparam logic [31:0] OFS_LEVEL     = 32'h0000_0008;
  localparam logic [31:0] OFS_CONTROL   = 32'h0000_000C;

  // Field position of the global pull-up disable in the control register
  localparam int unsigned CTRL_PUD_BIT = 0;

  // Values after reset
  localparam logic [PIN_COUNT-1:0] RST_DIRECTION = 8'h00;
  localparam logic [PIN_COUNT-1:0] RST_LATCH     = 8'h00;
  localparam logic                 RST_PUD       = 1'b0;

  // AXI response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ---- rtl/gpp_port_top.sv ----
// One eight-pin general-purpose port with an AXI4-Lite register slave,
// alternate-function overrides and the pin level synchroniser.
// Assumes overrides come from the peripherals that own them and that sleep
// and the interrupt enables come from the sleep and interrupt controllers.
`timescale 1ns/10ps
module gpp_port_top
  import gpp_pkg::*;
(
  input  wire logic                 sys_clk_i,
  input  wire logic                 nrst_i,
  // AXI4-Lite write address
  input  wire logic                 s_axi_awvalid_i,
  output logic                      s_axi_awready_o,
  input  wire logic [31:0]          s_axi_awaddr_i,
  // AXI4-Lite write data
  input  wire logic                 s_axi_wvalid_i,
  output logic                      s_axi_wready_o,
  input  wire logic [31:0]          s_axi_wdata_i,
  input  wire logic [3:0]           s_axi_wstrb_i,
  // AXI4-Lite write response
  output logic                      s_axi_bvalid_o,
  input  wire logic                 s_axi_bready_i,
  output logic [1:0]                s_axi_bresp_o,
  // AXI4-Lite read address
  input  wire logic                 s_axi_arvalid_i,
  output logic                      s_axi_arready_o,
  input  wire logic [31:0]          s_axi_araddr_i,
  // AXI4-Lite read data
  output logic                      s_axi_rvalid_o,
  input  wire logic                 s_axi_rready_i,
  output logic [31:0]               s_axi_rdata_o,
  output logic [1:0]                s_axi_rresp_o,
  // Shared controls from the sleep and interrupt controllers
  input  wire logic                 sleep_i,
  input  wire logic [PIN_COUNT-1:0] ext_int_enable_i,
  // Per-pin overrides from alternate-function peripherals
  input  wire logic [PIN_COUNT-1:0] pullup_override_enable_i,
  input  wire logic [PIN_COUNT-1:0] pullup_override_value_i,
  input  wire logic [PIN_COUNT-1:0] direction_override_enable_i,
  input  wire logic [PIN_COUNT-1:0] direction_override_value_i,
  input  wire logic [PIN_COUNT-1:0] drive_value_override_enable_i,
  input  wire logic [PIN_COUNT-1:0] drive_value_override_value_i,
  input  wire logic [PIN_COUNT-1:0] latch_invert_override_enable_i,
  input  wire logic [PIN_COUNT-1:0] input_enable_override_enable_i,
  input  wire logic [PIN_COUNT-1:0] input_enable_override_value_i,
  // Pads
  input  wire logic [PIN_COUNT-1:0] pad_i,
  output logic      [PIN_COUNT-1:0] pad_o,
  output logic      [PIN_COUNT-1:0] pad_oe_o,
  output logic      [PIN_COUNT-1:0] pullup_en_o,
  // Alternate-function inputs
  output logic      [PIN_COUNT-1:0] alt_function_digital_in_o,
  output logic      [PIN_COUNT-1:0] alt_function_analog_pad_o
);

  // Register state
  logic [PIN_COUNT-1:0] direction_bit;
  logic [PIN_COUNT-1:0] next_direction_bit;
  logic [PIN_COUNT-1:0] output_latch_bit;
  logic [PIN_COUNT-1:0] next_output_latch_bit;
  logic                 global_pullup_disable;
  logic                 next_global_pullup_disable;
  logic [PIN_COUNT-1:0] sampled_level_bit;

  // Write channel state
  logic        aw_held;
  logic        next_aw_held;
  logic        w_held;
  logic        next_w_held;
  logic [31:0] wr_addr;
  logic [31:0] next_wr_addr;
  logic [31:0] wr_data;
  logic [31:0] next_wr_data;
  logic [3:0]  wr_strb;
  logic [3:0]  next_wr_strb;
  logic        bvalid;
  logic        next_bvalid;
  logic [1:0]  bresp;
  logic [1:0]  next_bresp;

  // Read channel state
  logic        rvalid;
  logic        next_rvalid;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic [1:0]  rresp;
  logic [1:0]  next_rresp;

  // Decoded strobes, shared by all pins of the port
  logic latch_write_strobe;
  logic dir_write_strobe;
  logic level_write_strobe;
  logic ctrl_write_strobe;
  logic latch_read_strobe;
  logic wr_commit;
  logic wr_mapped;
  logic aw_take;
  logic w_take;
  logic ar_take;

  // Per-pin result vectors
  logic [PIN_COUNT-1:0] pin_out;
  logic [PIN_COUNT-1:0] pin_oe;
  logic [PIN_COUNT-1:0] pin_pullup;
  logic [PIN_COUNT-1:0] pin_din;

  // Handshakes: one write and one read in flight at most
  assign s_axi_awready_o = !aw_held && !bvalid;
  assign s_axi_wready_o  = !w_held && !bvalid;
  assign s_axi_arready_o = !rvalid;
  assign s_axi_bvalid_o  = bvalid;
  assign s_axi_bresp_o   = bresp;
  assign s_axi_rvalid_o  = rvalid;
  assign s_axi_rdata_o   = rdata;
  assign s_axi_rresp_o   = rresp;

  assign aw_take = s_axi_awvalid_i && s_axi_awready_o;
  assign w_take  = s_axi_wvalid_i && s_axi_wready_o;
  assign ar_take = s_axi_arvalid_i && s_axi_arready_o;

  // Write decode once both address and data are held
  always_comb begin
    wr_commit          = aw_held && w_held && !bvalid;
    dir_write_strobe   = wr_commit && (wr_addr == OFS_DIRECTION) &&
                         wr_strb[0];
    latch_write_strobe = wr_commit && (wr_addr == OFS_LATCH) &&
                         wr_strb[0];
    level_write_strobe = wr_commit && (wr_addr == OFS_LEVEL) &&
                         wr_strb[0];
    ctrl_write_strobe  = wr_commit && (wr_addr == OFS_CONTROL) &&
                         wr_strb[0];
    wr_mapped          = (wr_addr == OFS_DIRECTION) ||
                         (wr_addr == OFS_LATCH) ||
                         (wr_addr == OFS_LEVEL) ||
                         (wr_addr == OFS_CONTROL);
  end

  // Write channel next state: address and data taken in either order
  always_comb begin
    next_aw_held = aw_held;
    next_w_held  = w_held;
    next_wr_addr = wr_addr;
    next_wr_data = wr_data;
    next_wr_strb = wr_strb;
    next_bvalid  = bvalid;
    next_bresp   = bresp;
    if (aw_take) begin
      next_aw_held = 1'b1;
      next_wr_addr = s_axi_awaddr_i;
    end
    if (w_take) begin
      next_w_held  = 1'b1;
      next_wr_data = s_axi_wdata_i;
      next_wr_strb = s_axi_wstrb_i;
    end
    if (wr_commit) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid && s_axi_bready_i) begin
      next_bvalid = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      wr_addr <= 32'h0000_0000;
      wr_data <= 32'h0000_0000;
      wr_strb <= 4'h0;
      bvalid  <= 1'b0;
      bresp   <= RESP_OKAY;
    end else begin
      aw_held <= next_aw_held;
      w_held  <= next_w_held;
      wr_addr <= next_wr_addr;
      wr_data <= next_wr_data;
      wr_strb <= next_wr_strb;
      bvalid  <= next_bvalid;
      bresp   <= next_bresp;
    end
  end

  // Port registers next values
  always_comb begin
    next_direction_bit         = direction_bit;
    next_output_latch_bit      = output_latch_bit;
    next_global_pullup_disable = global_pullup_disable;
    if (dir_write_strobe) begin
      next_direction_bit = wr_data[PIN_COUNT-1:0];
    end
    if (latch_write_strobe) begin
      next_output_latch_bit = wr_data[PIN_COUNT-1:0];
    end else if (level_write_strobe) begin
      // Ones toggle, zeros leave the bit alone
      next_output_latch_bit = output_latch_bit ^
                              wr_data[PIN_COUNT-1:0];
    end
    if (ctrl_write_strobe) begin
      next_global_pullup_disable = wr_data[CTRL_PUD_BIT];
    end
  end

  // Async reset makes every pin an input without pull-up at once
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      direction_bit         <= RST_DIRECTION;
      output_latch_bit      <= RST_LATCH;
      global_pullup_disable <= RST_PUD;
    end else begin
      direction_bit         <= next_direction_bit;
      output_latch_bit      <= next_output_latch_bit;
      global_pullup_disable <= next_global_pullup_disable;
    end
  end

  // Read decode and data mux
  always_comb begin
    latch_read_strobe = ar_take;
    next_rvalid       = rvalid;
    next_rdata        = rdata;
    next_rresp        = rresp;
    if (ar_take) begin
      next_rvalid = 1'b1;
      next_rresp  = RESP_OKAY;
      next_rdata  = 32'h0000_0000;
      unique case (s_axi_araddr_i)
        OFS_DIRECTION: next_rdata[PIN_COUNT-1:0] = direction_bit;
        OFS_LATCH:     next_rdata[PIN_COUNT-1:0] = output_latch_bit;
        OFS_LEVEL:     next_rdata[PIN_COUNT-1:0] = sampled_level_bit;
        OFS_CONTROL:   next_rdata[CTRL_PUD_BIT]  = global_pullup_disable;
        default:       next_rresp = RESP_SLVERR;
      endcase
    end else if (rvalid && s_axi_rready_i) begin
      next_rvalid = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= RESP_OKAY;
    end else begin
      rvalid <= next_rvalid;
      rdata  <= latch_read_strobe ? next_rdata : rdata;
      rresp  <= next_rresp;
    end
  end

  // Pin slices; overrides arrive from their peripherals unchanged
  gpp_pin_if pin_if [PIN_COUNT] ();

  for (genvar g = 0; g < PIN_COUNT; g++) begin : g_pin
    assign pin_if[g].direction_bit         = direction_bit[g];
    assign pin_if[g].output_latch_bit      = output_latch_bit[g];
    assign pin_if[g].global_pullup_disable = global_pullup_disable;
    assign pin_if[g].sleep                 = sleep_i;
    assign pin_if[g].ext_int_enable        = ext_int_enable_i[g];
    assign pin_if[g].reset_active          = !nrst_i;
    assign pin_if[g].pullup_override_enable =
      pullup_override_enable_i[g];
    assign pin_if[g].pullup_override_value  = pullup_override_value_i[g];
    assign pin_if[g].direction_override_enable =
      direction_override_enable_i[g];
    assign pin_if[g].direction_override_value =
      direction_override_value_i[g];
    assign pin_if[g].drive_value_override_enable =
      drive_value_override_enable_i[g];
    assign pin_if[g].drive_value_override_value =
      drive_value_override_value_i[g];
    assign pin_if[g].latch_invert_override_enable =
      latch_invert_override_enable_i[g];
    assign pin_if[g].input_enable_override_enable =
      input_enable_override_enable_i[g];
    assign pin_if[g].input_enable_override_value =
      input_enable_override_value_i[g];
    assign pin_if[g].pad_in = pad_i[g];
    assign pin_out[g]    = pin_if[g].pad_out;
    assign pin_oe[g]     = pin_if[g].pad_oe;
    assign pin_pullup[g] = pin_if[g].pullup_en;
    assign pin_din[g]    = pin_if[g].alt_function_digital_in;

    gpp_pin_slice u_slice (
      .p (pin_if[g])
    );
  end

  // Pad outputs
  assign pad_o       = pin_out;
  assign pad_oe_o    = pin_oe;
  assign pullup_en_o = pin_pullup;
  // Clamp release on wake shows as a rising edge to interrupt logic
  assign alt_function_digital_in_o = pin_din;
  // Analog path taken straight from the pad
  assign alt_function_analog_pad_o = pad_i;

  // Level synchroniser feeding the readable level bits
  gpp_level_sync #(
    .WIDTH (PIN_COUNT)
  ) u_level_sync (
    .sys_clk_i (sys_clk_i),
    .nrst_i    (nrst_i),
    .d_i       (pin_din),
    .q_o       (sampled_level_bit)
  );

endmodule

// ---- verification/gpp_pad_model.sv ----
// Model of circuitry on the pads: the port driver wins, then an outside
// source, then the pull-up; an undriven pin wanders every cycle.
// Assumes the same clock as the port.
`timescale 1ns/10ps
module gpp_pad_model
  import gpp_pkg::*;
(
  input  wire logic                 sys_clk_i,
  input  wire logic [PIN_COUNT-1:0] drive_i,
  input  wire logic [PIN_COUNT-1:0] drive_en_i,
  input  wire logic [PIN_COUNT-1:0] pullup_i,
  input  wire logic [PIN_COUNT-1:0] ext_en_i,
  input  wire logic [PIN_COUNT-1:0] ext_val_i,
  output logic      [PIN_COUNT-1:0] level_o
);
  logic [PIN_COUNT-1:0] drift = '0;

  // Floating level changes each cycle so it is never read as valid
  always_ff @(posedge sys_clk_i) begin
    drift <= ~drift;
  end

  // Resolve the wire level of each pin
  assign level_o = (drive_en_i & drive_i) |
                   (~drive_en_i & ext_en_i & ext_val_i) |
                   (~drive_en_i & ~ext_en_i & (pullup_i | drift));
endmodule

// ---- verification/gpp_port_chk.sv ----
// Checker for the port: pad control, input gating and read handshake.
// Assumes it is bound to gpp_port_top and sees only its ports.
`timescale 1ns/10ps
module gpp_port_chk
  import gpp_pkg::*;
(
  input wire logic                 sys_clk_i,
  input wire logic                 nrst_i,
  input wire logic                 s_axi_arvalid_i,
  input wire logic                 s_axi_arready_o,
  input wire logic                 s_axi_rvalid_o,
  input wire logic                 s_axi_rready_i,
  input wire logic [31:0]          s_axi_rdata_o,
  input wire logic                 sleep_i,
  input wire logic [PIN_COUNT-1:0] ext_int_enable_i,
  input wire logic [PIN_COUNT-1:0] pullup_override_enable_i,
  input wire logic [PIN_COUNT-1:0] pullup_override_value_i,
  input wire logic [PIN_COUNT-1:0] direction_override_enable_i,
  input wire logic [PIN_COUNT-1:0] direction_override_value_i,
  input wire logic [PIN_COUNT-1:0] drive_value_override_enable_i,
  input wire logic [PIN_COUNT-1:0] drive_value_override_value_i,
  input wire logic [PIN_COUNT-1:0] input_enable_override_enable_i,
  input wire logic [PIN_COUNT-1:0] input_enable_override_value_i,
  input wire logic [PIN_COUNT-1:0] pad_i,
  input wire logic [PIN_COUNT-1:0] pad_o,
  input wire logic [PIN_COUNT-1:0] pad_oe_o,
  input wire logic [PIN_COUNT-1:0] pullup_en_o,
  input wire logic [PIN_COUNT-1:0] alt_function_digital_in_o,
  input wire logic [PIN_COUNT-1:0] alt_function_analog_pad_o
);
  logic [PIN_COUNT-1:0] clamp;
  logic [PIN_COUNT-1:0] ie_ovr;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);

  // Pins the sleep clamp reaches, pins under input override
  assign clamp  = {PIN_COUNT{sleep_i}} & ~ext_int_enable_i & ~ie_ovr;
  assign ie_ovr = input_enable_override_enable_i;

  sequence read_taken;
    s_axi_arvalid_i && s_axi_arready_o;
  endsequence

  chk_pullup_override: assert property (
    (pullup_en_o & pullup_override_enable_i) ==
    (pullup_override_value_i & pullup_override_enable_i))
    else $error("pull-up differs from override value");
  chk_dir_override: assert property (
    (pad_oe_o & direction_override_enable_i) ==
    (direction_override_value_i & direction_override_enable_i))
    else $error("driver enable differs from override value");
  chk_value_override: assert property (
    ((pad_o ^ drive_value_override_value_i) & pad_oe_o &
     drive_value_override_enable_i) == '0)
    else $error("driven level differs from override value");
  chk_sleep_clamp: assert property (
    sleep_i |-> (alt_function_digital_in_o & clamp) == '0)
    else $error("clamped input not zero");
  chk_input_override: assert property (
    (alt_function_digital_in_o & ie_ovr) ==
    (pad_i & ie_ovr & input_enable_override_value_i))
    else $error("input enable override not obeyed");
  chk_raw_input: assert property (
    !sleep_i |-> ((alt_function_digital_in_o ^ pad_i) & ~ie_ovr) == '0)
    else $error("digital input differs from pad");
  chk_analog_pad: assert property (
    alt_function_analog_pad_o == pad_i)
    else $error("analog path differs from pad");
  chk_read_answer: assert property (
    read_taken |=> s_axi_rvalid_o)
    else $error("read data not returned one cycle after address");
  chk_read_hold: assert property (
    s_axi_rvalid_o && !s_axi_rready_i |=>
    s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read data dropped before accepted");
endmodule

bind gpp_port_top gpp_port_chk u_gpp_port_chk (.*);

// ---- verification/port_pin_sync_and_override_test.sv ----
// Testbench for the port: register access over AXI4-Lite, overrides,
// sleep clamp and synchroniser timing, with a pad model on the pins.
// Assumes gpp_port_top, gpp_pad_model and the bound checker.
`timescale 1ns/10ps
module port_pin_sync_and_override_test
  import gpp_pkg::*;
;
  logic        sys_clk = 0;
  logic        nrst_n  = 0;
  logic        aw_v = 0, w_v = 0, b_r = 0, ar_v = 0, r_r = 0, sleep = 0;
  logic [31:0] aw_a = '0, w_d = '0, ar_a = '0, rdat;
  logic [7:0]  ext_int = '0, pue = '0, puv = '0, doe = '0, dov = '0;
  logic [7:0]  dve = '0, dvv = '0, tie = '0, iee = '0, iev = '0;
  logic [7:0]  ext_en = '0, ext_val = '0;
  logic [7:0]  pad_in, pad_out, pad_oe, pu_en, alt_in, alt_an;
  logic [1:0]  bresp, rresp;
  logic [3:0]  strb = 4'hF;
  logic        awr, wr_rdy, bv, arr, rv;
  int          miscompares = 0;
  int          tests_run = 0;

  // Clock
  always #25 sys_clk = ~sys_clk;

  gpp_port_top u_gpp_port_top (
    .sys_clk_i(sys_clk), .nrst_i(nrst_n), .s_axi_awvalid_i(aw_v),
    .s_axi_awready_o(awr), .s_axi_awaddr_i(aw_a), .s_axi_wvalid_i(w_v),
    .s_axi_wready_o(wr_rdy), .s_axi_wdata_i(w_d), .s_axi_wstrb_i(strb),
    .s_axi_bvalid_o(bv), .s_axi_bready_i(b_r), .s_axi_bresp_o(bresp),
    .s_axi_arvalid_i(ar_v), .s_axi_arready_o(arr), .s_axi_araddr_i(ar_a),
    .s_axi_rvalid_o(rv), .s_axi_rready_i(r_r), .s_axi_rdata_o(rdat),
    .s_axi_rresp_o(rresp), .sleep_i(sleep), .ext_int_enable_i(ext_int),
    .pullup_override_enable_i(pue), .pullup_override_value_i(puv),
    .direction_override_enable_i(doe), .direction_override_value_i(dov),
    .drive_value_override_enable_i(dve), .drive_value_override_value_i(dvv),
    .latch_invert_override_enable_i(tie),
    .input_enable_override_enable_i(iee),
    .input_enable_override_value_i(iev), .pad_i(pad_in), .pad_o(pad_out),
    .pad_oe_o(pad_oe), .pullup_en_o(pu_en),
    .alt_function_digital_in_o(alt_in), .alt_function_analog_pad_o(alt_an)
  );

  gpp_pad_model u_gpp_pad_model (
    .sys_clk_i(sys_clk), .drive_i(pad_out), .drive_en_i(pad_oe),
    .pullup_i(pu_en), .ext_en_i(ext_en), .ext_val_i(ext_val),
    .level_o(pad_in)
  );

  task automatic check(input string name, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [31:0] a, d, input logic [1:0] resp);
    logic ta, tw, da = 0, dw = 0;
    aw_v <= 1; w_v <= 1; aw_a <= a; w_d <= d; b_r <= 1;
    while (!(da && dw)) begin
      @(negedge sys_clk);
      ta = aw_v & awr;
      tw = w_v & wr_rdy;
      @(posedge sys_clk);
      if (ta) aw_v <= 0;
      if (tw) w_v <= 0;
      da |= ta;
      dw |= tw;
    end
    do @(negedge sys_clk); while (!bv);
    check("write response", 32'(bresp), 32'(resp));
    // Ready stays high so a following call never sets it twice in one step
    @(posedge sys_clk);
  endtask

  task automatic rd(input logic [31:0] a, exp, input logic [1:0] resp);
    ar_v <= 1; ar_a <= a; r_r <= 1;
    do @(negedge sys_clk); while (!arr);
    @(posedge sys_clk);
    ar_v <= 0;
    do @(negedge sys_clk); while (!rv);
    check("read data", rdat, exp);
    check("read response", 32'(rresp), 32'(resp));
    // Ready stays high so a following call never sets it twice in one step
    @(posedge sys_clk);
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (5) @(posedge sys_clk);
    check("oe in reset", 32'(pad_oe), 32'h0);
    nrst_n <= 1;
    rd(OFS_DIRECTION, 32'h0, RESP_OKAY);
    rd(OFS_LATCH, 32'h0, RESP_OKAY);
    rd(OFS_CONTROL, 32'h0, RESP_OKAY);
    wr(OFS_LATCH, 32'hFF, RESP_OKAY);
    check("pull-up on", 32'(pu_en), 32'hFF);
    nrst_n <= 0;
    @(negedge sys_clk);
    check("pull-up in reset", 32'(pu_en), 32'h0);
    check("oe in reset", 32'(pad_oe), 32'h0);
    @(posedge sys_clk);
    nrst_n <= 1;
    rd(OFS_LATCH, 32'h0, RESP_OKAY);
    ext_en <= 8'hF0;
    ext_val <= 8'hA0;
    wr(OFS_DIRECTION, 32'h0F, RESP_OKAY);
    wr(OFS_LATCH, 32'h33, RESP_OKAY);
    check("oe", 32'(pad_oe), 32'h0F);
    check("drive", 32'(pad_out & pad_oe), 32'h03);
    check("pull-up", 32'(pu_en), 32'h30);
    rd(OFS_LEVEL, 32'hA3, RESP_OKAY);
    wr(OFS_CONTROL, 32'h1, RESP_OKAY);
    check("pull-up off", 32'(pu_en), 32'h0);
    wr(OFS_LEVEL, 32'h0F, RESP_OKAY);
    wr(OFS_LEVEL, 32'h00, RESP_OKAY);
    rd(OFS_LATCH, 32'h3C, RESP_OKAY);
    // Write without the low byte strobe leaves the latch alone
    strb <= 4'hE;
    wr(OFS_LATCH, 32'h00, RESP_OKAY);
    strb <= 4'hF;
    rd(OFS_LATCH, 32'h3C, RESP_OKAY);
    wr(32'h10, 32'h1, RESP_SLVERR);
    rd(32'h10, 32'h0, RESP_SLVERR);
    doe <= 8'hFF; dov <= 8'hAA; pue <= 8'hFF; puv <= 8'h55;
    dve <= 8'h0F; dvv <= 8'h05;
    @(negedge sys_clk);
    check("oe override", 32'(pad_oe), 32'hAA);
    check("pull-up override", 32'(pu_en), 32'h55);
    check("value override", 32'(pad_out & pad_oe), 32'h20);
    @(posedge sys_clk);
    dve <= 8'h00;
    tie <= 8'hFF;
    @(negedge sys_clk);
    check("toggle override", 32'(pad_out & pad_oe), 32'h82);
    @(posedge sys_clk);
    doe <= '0; pue <= '0; tie <= '0;
    sleep <= 1; ext_int <= 8'h01; iee <= 8'h06; iev <= 8'h02;
    ext_en <= 8'hFF;
    ext_val <= 8'hFF;
    wr(OFS_DIRECTION, 32'h0, RESP_OKAY);
    @(negedge sys_clk);
    check("clamp", 32'(alt_in), 32'h03);
    check("analog", 32'(alt_an), 32'hFF);
    rd(OFS_LEVEL, 32'h03, RESP_OKAY);
    sleep <= 0;
    @(negedge sys_clk);
    check("awake input", 32'(alt_in), 32'hFB);
    @(posedge sys_clk);
    iee <= '0;
    ext_val <= 8'h00;
    rd(OFS_LEVEL, 32'hFB, RESP_OKAY);
    rd(OFS_LEVEL, 32'h00, RESP_OKAY);
    finish_test();
  end

  // Watchdog
  initial begin
    repeat (5000) @(posedge sys_clk);
    miscompares++;
    finish_test();
  end
endmodule
